// [rtl/iocr_pkg.sv]
// shared constants and types for the io cell register block
package iocr_pkg;

    // ==========================================================
    // widths
    localparam int MEM_BUS_W = 16;             // widest memory bus
    localparam int GROUPS    = 2;              // strobe groups the bus is split into
    localparam int DQ_W      = MEM_BUS_W / GROUPS;
    localparam int CAL_W     = 6;              // dll calibration code
    localparam int HIST_N    = 1 << CAL_W;     // strobe delay taps
    localparam int GB_W      = 8;              // gearbox parallel word
    localparam int LANE_W    = 4;              // one 1:4 lane
    localparam int ADDR_W    = 2;
    localparam int DATA_W    = 8;

    // ==========================================================
    // register map
    localparam logic [ADDR_W-1:0] REG_CTRL = 2'h0;
    localparam logic [ADDR_W-1:0] REG_STAT = 2'h1;
    localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
    localparam logic [DATA_W-1:0] RD_IDLE  = 8'h00;

    // ==========================================================
    // gearbox last bit index per word
    localparam logic [2:0] LAST_SEVEN = 3'h6;
    localparam logic [2:0] LAST_EIGHT = 3'h7;
    localparam logic [2:0] LAST_FOUR  = 3'h3;
    localparam logic [2:0] CNT_ZERO   = 3'h0;

    // ==========================================================
    // modes and states
    typedef enum logic [1:0] {
        OM_SDR_FF    = 2'h0,
        OM_SDR_LATCH = 2'h1,
        OM_DDR_GEN   = 2'h2,
        OM_DDR_MEM   = 2'h3
    } iocr_omode_e;

    typedef enum logic [1:0] {
        GB_DESER_BY_SEVEN = 2'h0,
        GB_EIGHT_MODE     = 2'h1,
        GB_FOUR_MODE      = 2'h2
    } iocr_gbmode_e;

    typedef enum logic [3:0] {
        RS_IDLE = 4'h1,
        RS_ARM  = 4'h2,
        RS_PRE  = 4'h4,
        RS_ACT  = 4'h8
    } iocr_rdst_e;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic         rd_en;   // bit 4
        iocr_gbmode_e gb;      // bits 3:2
        iocr_omode_e  om;      // bits 1:0
    } iocr_cfg_s;

    localparam int CFG_W = $bits(iocr_cfg_s);

    typedef struct packed {
        logic [DQ_W-1:0] rise;
        logic [DQ_W-1:0] fall;
    } iocr_rdw_s;

endpackage : iocr_pkg

// [rtl/iocr_top.sv]
// io cell group: ddr in/out registers, strobe block and input gearbox
module iocr_top
    import iocr_pkg::*;
(
    // clock, reset, enable
    input  wire logic                       i_mclk,
    input  wire logic                       i_rstn,
    input  wire logic                       i_ce,
    // register port
    input  wire logic [iocr_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [iocr_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                       i_wr,
    input  wire logic                       i_rd,
    output logic      [iocr_pkg::DATA_W-1:0] o_rdata,
    // core side data
    input  wire logic [iocr_pkg::DQ_W-1:0]  i_rise_word_in,
    input  wire logic [iocr_pkg::DQ_W-1:0]  i_fall_word_in,
    input  wire logic                       i_tristate_sdr_in,
    input  wire logic                       i_tristate_ddr_in,
    output iocr_pkg::iocr_rdw_s             o_read_word,
    output logic                            o_read_word_valid,
    // dll calibration
    input  wire logic [iocr_pkg::CAL_W-1:0] i_delay_code,
    // pads
    input  wire logic [iocr_pkg::DQ_W-1:0]  i_dq_pad,
    output logic      [iocr_pkg::DQ_W-1:0]  o_dq_pad,
    output logic                            o_dq_oe_n,
    input  wire logic                       i_strobe_pad,
    // strobes routed to the group
    output logic                            o_read_capture_strobe,
    output logic                            o_write_launch_strobe,
    output logic                            o_sync_clock_polarity,
    // input gearbox
    input  wire logic                       i_gb_ser_a,
    input  wire logic                       i_gb_ser_c,
    input  wire logic [1:0]                 i_fast_edge_clock,
    input  wire logic                       i_word_slip_request,
    input  wire logic                       i_gb_reset,
    output logic      [iocr_pkg::GB_W-1:0]  o_gb_word,
    output logic                            o_gb_word_valid
);
    import iocr_pkg::*;

    // ==========================================================
    // helpers
    function automatic logic rise_of(input logic prev, input logic cur);
        return cur & ~prev;
    endfunction : rise_of

    function automatic logic fall_of(input logic prev, input logic cur);
        return prev & ~cur;
    endfunction : fall_of

    function automatic logic [2:0] last_idx(input iocr_gbmode_e m);
        unique case (m)
            GB_DESER_BY_SEVEN: return LAST_SEVEN;
            GB_FOUR_MODE:      return LAST_FOUR;
            default:           return LAST_EIGHT; // code 3 acts as 1:8
        endcase
    endfunction : last_idx

    // ==========================================================
    // pin synchronisers, stage one read only by stage two
    logic [DQ_W-1:0] dq_s1_q, dq_s2_q;     // half of the bus
    logic [4:0]      pin_s1_q, pin_s2_q;   // strobe, ser a, ser c, ecl
    logic            strb_s2, ser_a_s2, ser_c_s2, ecl0_s2, ecl1_s2;

    always_ff @(posedge i_mclk) begin
        if (i_ce) begin
            dq_s1_q  <= i_dq_pad;
            dq_s2_q  <= dq_s1_q;
            pin_s1_q <= {i_strobe_pad, i_gb_ser_a, i_gb_ser_c,
                         i_fast_edge_clock};
            pin_s2_q <= pin_s1_q;
        end
    end
    assign {strb_s2, ser_a_s2, ser_c_s2, ecl1_s2, ecl0_s2} = pin_s2_q;

    // ==========================================================
    // register port
    iocr_cfg_s       cfg_q;
    iocr_rdst_e      st_q;
    logic            pol_q, pend_q;
    logic [DATA_W-1:0] stat;

    assign stat = DATA_W'({pend_q, pol_q, st_q});

    // config write; read data valid only the cycle after the strobe
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            cfg_q   <= iocr_cfg_s'(CTRL_RST[CFG_W-1:0]);
            o_rdata <= RD_IDLE;
        end else if (i_ce) begin
            if (i_wr && i_addr == REG_CTRL)
                cfg_q <= iocr_cfg_s'(i_wdata[CFG_W-1:0]);
            if (!i_rd)
                o_rdata <= RD_IDLE;
            else if (i_addr == REG_CTRL)
                o_rdata <= DATA_W'(cfg_q);
            else if (i_addr == REG_STAT)
                o_rdata <= stat;
            else
                o_rdata <= RD_IDLE;
        end
    end

    // ==========================================================
    // system clock phase: ph_q is the half-rate core clock level
    logic ph_q;
    logic srise, sfall;

    always_ff @(posedge i_mclk) begin
        if (!i_rstn)
            ph_q <= 1'b0;
        else if (i_ce)
            ph_q <= ~ph_q;
    end
    assign srise = ~ph_q;   // core clock rises at this edge
    assign sfall = ph_q;

    // ==========================================================
    // strobe block: tapped delay of the incoming strobe
    logic [HIST_N-1:0] hist_q;
    logic rc_lvl, wl_lvl, rc_prev_q, wl_prev_q;
    logic rc_rise, rc_fall, wl_rise;

    // taps chosen by the dll code track drift
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            hist_q    <= '0;
            rc_prev_q <= 1'b0;
            wl_prev_q <= 1'b0;
        end else if (i_ce) begin
            hist_q    <= {hist_q[HIST_N-2:0], strb_s2};
            rc_prev_q <= rc_lvl;
            wl_prev_q <= wl_lvl;
        end
    end
    // read strobe at full code, write strobe at half of it
    assign rc_lvl  = hist_q[i_delay_code];
    assign wl_lvl  = hist_q[i_delay_code >> 1];
    assign rc_rise = rise_of(rc_prev_q, rc_lvl);
    assign rc_fall = fall_of(rc_prev_q, rc_lvl);
    assign wl_rise = rise_of(wl_prev_q, wl_lvl);

    // strobes and polarity leave as registered group signals
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_read_capture_strobe <= 1'b0;
            o_write_launch_strobe <= 1'b0;
            o_sync_clock_polarity <= 1'b0;
        end else if (i_ce) begin
            o_read_capture_strobe <= rc_lvl;
            o_write_launch_strobe <= wl_lvl;
            o_sync_clock_polarity <= pol_q;
        end
    end

    // ==========================================================
    // read cycle tracking and polarity detection
    // the strobe phase is unknown, so it is learnt again each time rd_en is set
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            st_q  <= RS_IDLE;
            pol_q <= 1'b0;
        end else if (i_ce) begin
            unique case (st_q)
                RS_IDLE: if (cfg_q.rd_en) st_q <= RS_ARM;
                // low strobe after the undriven gap marks preamble
                RS_ARM: begin
                    if (!cfg_q.rd_en) st_q <= RS_IDLE;
                    else if (!rc_lvl) st_q <= RS_PRE;
                end
                RS_PRE: begin
                    if (!cfg_q.rd_en) st_q <= RS_IDLE;
                    else if (rc_rise) begin
                        pol_q <= ph_q;
                        st_q  <= RS_ACT;
                    end
                end
                RS_ACT: if (!cfg_q.rd_en) st_q <= RS_IDLE;
                default: st_q <= RS_IDLE;
            endcase
        end
    end

    // ==========================================================
    // read capture in the strobe timing
    iocr_rdw_s cap_q;
    logic      cap_en, xfer;

    assign cap_en = (st_q == RS_PRE) || (st_q == RS_ACT);

    always_ff @(posedge i_mclk) begin
        if (!i_rstn)
            cap_q <= '0;
        else if (i_ce && cap_en) begin
            if (rc_rise) cap_q.rise <= dq_s2_q;
            if (rc_fall) cap_q.fall <= dq_s2_q;
        end
    end

    // pair complete on the fall; new data wins over the transfer
    assign xfer = pend_q && (ph_q == pol_q);

    always_ff @(posedge i_mclk) begin
        if (!i_rstn)
            pend_q <= 1'b0;
        else if (i_ce)
            pend_q <= (cap_en && rc_fall) || (pend_q && !xfer);
    end

    // resync into the core domain on the chosen phase
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_read_word       <= '0;
            o_read_word_valid <= 1'b0;
        end else if (i_ce) begin
            o_read_word_valid <= xfer;
            if (xfer) o_read_word <= cap_q;
        end
    end

    // ==========================================================
    // output stage registers
    logic [DQ_W-1:0] rise_stage_q, fall_hold_q, fall_stage_q;

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            rise_stage_q <= '0;
            fall_hold_q  <= '0;
            fall_stage_q <= '0;
        end else if (i_ce) begin
            if (srise) begin
                rise_stage_q <= i_rise_word_in;
                fall_hold_q  <= i_fall_word_in;
            end
            if (sfall) fall_stage_q <= fall_hold_q;
        end
    end

    // pad data; every mode ends in this one flop, adding a cycle
    always_ff @(posedge i_mclk) begin
        if (!i_rstn)
            o_dq_pad <= '0;
        else if (i_ce) begin
            unique case (cfg_q.om)
                OM_SDR_FF:
                    if (srise) o_dq_pad <= i_rise_word_in;
                // latch follows the input while core clock is high
                OM_SDR_LATCH:
                    if (sfall) o_dq_pad <= i_rise_word_in;
                OM_DDR_GEN:
                    o_dq_pad <= ph_q ? fall_stage_q
                                     : rise_stage_q;
                OM_DDR_MEM:
                    o_dq_pad <= wl_lvl ? rise_stage_q
                                       : fall_stage_q;
            endcase
        end
    end

    // ==========================================================
    // tristate path, high input means pad released
    logic ts_sdr_q, ts_mem_q;

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            ts_sdr_q  <= 1'b1;
            ts_mem_q  <= 1'b1;
            o_dq_oe_n <= 1'b1;
        end else if (i_ce) begin
            if (srise) ts_sdr_q <= i_tristate_sdr_in;
            if (wl_rise) ts_mem_q <= i_tristate_ddr_in;
            o_dq_oe_n <= (cfg_q.om == OM_DDR_MEM) ? ts_mem_q
                                                  : ts_sdr_q;
        end
    end

    // ==========================================================
    // input gearbox, one bit per fast clock edge of either sense
    logic [GB_W-1:0]   sh_a_q;
    logic [LANE_W-1:0] sh_c_q, word_c_q, c_word;
    logic [2:0]        cnt_a_q, cnt_c_q;
    logic              ecl0_prev_q, ecl1_prev_q, slip_q;
    logic              a_bit, c_bit, four, a_done, c_done;

    assign four   = (cfg_q.gb == GB_FOUR_MODE);
    assign a_bit  = rise_of(ecl0_prev_q, ecl0_s2)
                  | fall_of(ecl0_prev_q, ecl0_s2);
    assign c_bit  = four & (rise_of(ecl1_prev_q, ecl1_s2)
                  | fall_of(ecl1_prev_q, ecl1_s2));
    assign a_done = a_bit && !slip_q
                  && cnt_a_q == last_idx(cfg_q.gb);
    // lane c nibble, usable in the very cycle that completes it
    assign c_done = c_bit && !slip_q && cnt_c_q == LAST_FOUR;
    assign c_word = {sh_c_q[LANE_W-2:0], ser_c_s2};

    // a held slip skips one count, moving the frame by a bit
    always_ff @(posedge i_mclk) begin
        if (!i_rstn || i_gb_reset) begin
            slip_q  <= 1'b0;
            cnt_a_q <= CNT_ZERO;
            cnt_c_q <= CNT_ZERO;
        end else if (i_ce) begin
            slip_q <= i_word_slip_request
                    || (slip_q && !a_bit);
            if (a_bit && !slip_q)
                cnt_a_q <= a_done ? CNT_ZERO : cnt_a_q + 3'h1;
            if (c_bit && !slip_q)
                cnt_c_q <= (cnt_c_q == LAST_FOUR) ? CNT_ZERO
                                                  : cnt_c_q + 3'h1;
        end
    end

    // shifters and edge history
    always_ff @(posedge i_mclk) begin
        if (!i_rstn || i_gb_reset) begin
            sh_a_q      <= '0;
            sh_c_q      <= '0;
            word_c_q    <= '0;
            ecl0_prev_q <= ecl0_s2;    // a parked clock is no edge
            ecl1_prev_q <= ecl1_s2;
        end else if (i_ce) begin
            ecl0_prev_q <= ecl0_s2;
            ecl1_prev_q <= ecl1_s2;
            if (a_bit) sh_a_q <= {sh_a_q[GB_W-2:0], ser_a_s2};
            if (c_bit) sh_c_q <= {sh_c_q[LANE_W-2:0], ser_c_s2};
            if (c_done) word_c_q <= c_word;
        end
    end

    // parallel word placement by mode
    always_ff @(posedge i_mclk) begin
        if (!i_rstn || i_gb_reset) begin
            o_gb_word       <= '0;
            o_gb_word_valid <= 1'b0;
        end else if (i_ce) begin
            o_gb_word_valid <= a_done;
            if (a_done) begin
                unique case (cfg_q.gb)
                    GB_DESER_BY_SEVEN:
                        o_gb_word <= {1'b0, sh_a_q[5:0], ser_a_s2};
                    GB_FOUR_MODE:
                        o_gb_word <= {sh_a_q[2:0], ser_a_s2,
                                      c_done ? c_word : word_c_q};
                    default:
                        o_gb_word <= {sh_a_q[6:0], ser_a_s2};
                endcase
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    cap_rise_a: assert property (i_ce && cap_en && rc_rise |=>
        cap_q.rise == $past(dq_s2_q)) else $error("rise capture lost");
    resync_word_a: assert property (i_ce && xfer |=>
        o_read_word_valid && o_read_word == $past(cap_q))
        else $error("read word not moved");
    resync_phase_a: assert property (o_read_word_valid |->
        $past(ph_q) == pol_q) else $error("resync on wrong phase");
    sdr_flop_a: assert property (i_ce && cfg_q.om == OM_SDR_FF
        && srise |=> o_dq_pad == $past(i_rise_word_in))
        else $error("sdr pad not loaded");
    fall_move_a: assert property (i_ce && sfall |=>
        fall_stage_q == $past(fall_hold_q))
        else $error("fall stage not moved");
    gen_mux_a: assert property (i_ce && cfg_q.om == OM_DDR_GEN
        |=> o_dq_pad == ($past(ph_q) ? $past(fall_stage_q)
                                     : $past(rise_stage_q)))
        else $error("generic mux wrong");
    mem_mux_a: assert property (i_ce && cfg_q.om == OM_DDR_MEM
        |=> o_dq_pad == ($past(wl_lvl) ? $past(rise_stage_q)
                                       : $past(fall_stage_q)))
        else $error("memory mux wrong");
    ts_sdr_a: assert property (i_ce && cfg_q.om != OM_DDR_MEM
        |=> o_dq_oe_n == $past(ts_sdr_q)) else $error("sdr oe wrong");
    ts_mem_a: assert property (i_ce && wl_rise ##1 i_ce
        && cfg_q.om == OM_DDR_MEM |=> o_dq_oe_n == $past(ts_mem_q)
        && ts_mem_q == $past(i_tristate_ddr_in, 2))
        else $error("memory oe wrong");
    pol_learn_a: assert property (i_ce && st_q == RS_PRE
        && cfg_q.rd_en && rc_rise |=> st_q == RS_ACT
        && pol_q == $past(ph_q)) else $error("polarity not learnt");
    rearm_read_a: assert property (i_ce && st_q == RS_IDLE
        && cfg_q.rd_en |=> st_q == RS_ARM) else $error("no rearm");
    word_slip_a: assert property (i_ce && !i_gb_reset
        && slip_q && a_bit |=> cnt_a_q == $past(cnt_a_q) && !slip_q
        || $past(i_word_slip_request)) else $error("slip not taken");

endmodule : iocr_top

// [bench/iocr_far_end.sv]
// far side model: memory strobe and data, serial transmitter
module iocr_far_end (
    // memory side
    output logic       o_strobe,
    output logic [7:0] o_dq,
    // serial side
    output logic       o_ser_a,
    output logic       o_ser_c,
    output logic [1:0] o_fclk
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // idle levels: strobe released, terminated high
    initial begin
        o_strobe = 1'b1;
        o_dq     = 8'h00;
        o_ser_a  = 1'b0;
        o_ser_c  = 1'b0;
        o_fclk   = 2'h0;
    end

    // one read burst: preamble low, then one strobe period
    task automatic burst(input logic [7:0] r, input logic [7:0] f);
        o_strobe = 1'b0;    // drive low to open the preamble
        #400;
        o_dq = r;           // data centred on each strobe edge
        #100 o_strobe = 1'b1;
        #100 o_dq = f;
        #100 o_strobe = 1'b0;
        #100 o_dq = ~f;     // released bus: inverse of last value
        #200 o_strobe = 1'b1;   // released strobe floats high
    endtask : burst

    // n bits msb first, one bit per fast clock edge, clock then parks
    task automatic send(input logic [7:0] a, input logic [7:0] c,
                        input int n);
        for (int i = n - 1; i >= 0; i--) begin
            o_ser_a = a[i];
            o_ser_c = c[i];
            #100 o_fclk = ~o_fclk;  // both edges carry a bit
            #100;
        end
        o_ser_a = ~o_ser_a;
        o_ser_c = ~o_ser_c;
    endtask : send
endmodule : iocr_far_end

// [bench/testbench.sv]
// self-checking testbench for the io cell register block
`define CHECK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import iocr_pkg::*;

    // ==========================================================
    // signals
    logic                mclk = 1'b0;
    logic                rstn, wr, rd, ts_sdr, ts_ddr, slip, gb_rst;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata, rdata, d;
    logic [DQ_W-1:0]     rise_in, fall_in, dq_out, dq_in, a, b;
    logic [CAL_W-1:0]    dcode;
    iocr_rdw_s           rword, rword_q;
    logic                rvalid, oe_n, rcs, wls, pol, gvalid;
    logic                strobe, ser_a, ser_c;
    logic [1:0]          fclk;
    logic [GB_W-1:0]     gword, gword_q;
    int                  n_mismatch = 0;
    int                  comparisons = 0;
    int                  nval = 0;

    always #25 mclk = ~mclk;

    iocr_top uut (.i_mclk(mclk), .i_rstn(rstn), .i_ce(1'b1),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_rise_word_in(rise_in),
        .i_fall_word_in(fall_in), .i_tristate_sdr_in(ts_sdr),
        .i_tristate_ddr_in(ts_ddr), .o_read_word(rword),
        .o_read_word_valid(rvalid), .i_delay_code(dcode),
        .i_dq_pad(dq_in), .o_dq_pad(dq_out), .o_dq_oe_n(oe_n),
        .i_strobe_pad(strobe), .o_read_capture_strobe(rcs),
        .o_write_launch_strobe(wls), .o_sync_clock_polarity(pol),
        .i_gb_ser_a(ser_a), .i_gb_ser_c(ser_c),
        .i_fast_edge_clock(fclk), .i_word_slip_request(slip),
        .i_gb_reset(gb_rst), .o_gb_word(gword),
        .o_gb_word_valid(gvalid));

    iocr_far_end far (.o_strobe(strobe), .o_dq(dq_in),
        .o_ser_a(ser_a), .o_ser_c(ser_c), .o_fclk(fclk));

    // keep the last word of each stream; valids are one-cycle pulses
    always @(posedge mclk) begin
        if (rvalid === 1'b1) begin
            rword_q <= rword;
            nval    <= nval + 1;
        end
        if (gvalid === 1'b1) begin
            gword_q <= gword;
        end
    end

    // ==========================================================
    // access tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc

    task automatic wr_reg(input logic [1:0] ad, input logic [7:0] dt);
        @(posedge mclk);
        addr  <= ad;
        wdata <= dt;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask : wr_reg

    // read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [1:0] ad);
        @(posedge mclk);
        addr <= ad;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    // mode write, then gearbox reset as a one-cycle pulse
    task automatic gb_restart(input logic [7:0] mode);
        wr_reg(REG_CTRL, mode);
        @(posedge mclk);
        gb_rst <= 1'b1;
        @(posedge mclk);
        gb_rst <= 1'b0;
        cyc(2);
    endtask : gb_restart

    task automatic tdone(input string s);
        $display("test %s done", s);
    endtask : tdone

    // single exit for both the normal end and the watchdog
    task automatic print_verdict;
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    // ==========================================================
    // test sequence
    initial begin
        {rstn, wr, rd, slip, gb_rst} = 5'h00;
        {ts_sdr, ts_ddr} = 2'h3;
        {addr, wdata, rise_in, fall_in, dcode} = '0;
        cyc(4);
        rstn <= 1'b1;
        #1 `CHECK(oe_n, 1'b1)
        rd_reg(REG_CTRL);
        `CHECK(d, CTRL_RST)
        rd_reg(REG_STAT);
        `CHECK(d, 8'h01)
        wr_reg(REG_CTRL, 8'h0E);
        wr_reg(REG_STAT, 8'hFF);
        wr_reg(2'h2, 8'hFF);
        rd_reg(REG_CTRL);
        `CHECK(d, 8'h0E)
        rd_reg(2'h2);
        `CHECK(d, RD_IDLE)
        rd_reg(REG_STAT);
        `CHECK(d, 8'h01)
        tdone("registers");
        wr_reg(REG_CTRL, 8'h00);
        rise_in <= 8'hA5;
        ts_sdr  <= 1'b0;
        cyc(6);
        `CHECK(dq_out, 8'hA5)
        `CHECK(oe_n, 1'b0)
        wr_reg(REG_CTRL, 8'h01);
        rise_in <= 8'h5A;
        cyc(6);
        `CHECK(dq_out, 8'h5A)
        wr_reg(REG_CTRL, 8'h02);
        rise_in <= 8'h3C;
        fall_in <= 8'hC3;
        cyc(6);
        #1 a = dq_out;
        @(posedge mclk);
        #1 b = dq_out;
        `CHECK({a,b} == 16'h3CC3 || {a,b} == 16'hC33C, 1'b1)
        tdone("output");
        wr_reg(REG_CTRL, 8'h13);
        {ts_sdr, ts_ddr} <= 2'h2;
        cyc(6);
        `CHECK(dq_out, 8'h3C)
        rd_reg(REG_STAT);
        `CHECK(d[3:0], 4'h2)
        far.burst(8'h96, 8'h69);
        cyc(6);
        `CHECK(rword_q, 16'h9669)
        `CHECK(nval, 1)
        `CHECK(oe_n, 1'b0)
        `CHECK({rcs, wls}, 2'h3)
        rd_reg(REG_STAT);
        `CHECK(d[4], pol)
        wr_reg(REG_CTRL, 8'h03);
        wr_reg(REG_CTRL, 8'h13);
        far.burst(8'h11, 8'hEE);
        cyc(6);
        `CHECK(rword_q, 16'h11EE)
        `CHECK(nval, 2)
        tdone("read");
        gb_restart(8'h04);
        far.send(8'hA7, 8'h00, 8);
        cyc(8);
        `CHECK(gword_q, 8'hA7)
        gb_restart(8'h00);
        far.send(8'h5B, 8'h00, 7);
        cyc(8);
        `CHECK(gword_q, 8'h5B)
        gb_restart(8'h04);
        @(posedge mclk);
        slip <= 1'b1;
        @(posedge mclk);
        slip <= 1'b0;
        far.send(8'h01, 8'h00, 1);
        far.send(8'hC3, 8'h00, 8);
        cyc(8);
        `CHECK(gword_q, 8'hC3)
        gb_restart(8'h08);
        far.send(8'h95, 8'h6A, 8);
        cyc(8);
        `CHECK(gword_q, 8'h5A)
        tdone("gearbox");
        print_verdict();
    end

    // watchdog well beyond the expected run of about 15 us
    initial begin
        #200000;
        n_mismatch++;
        print_verdict();
    end
endmodule : testbench
